//--- hdl/ebt_params.svh
// offsets, field positions, reset values and timing counts of the 8-bit timer
// assumes byte addressing on a 32-bit Avalon-MM register bus
`ifndef EBT_PARAMS_SVH
`define EBT_PARAMS_SVH

// register byte offsets
`define EBT_ADDR_COUNT 4'h0
`define EBT_ADDR_CFG 4'h4
`define EBT_ADDR_INTCTL 4'h8

// configuration register fields
`define EBT_CFG_SRC 5
`define EBT_CFG_EDGE 4
`define EBT_CFG_PSA 3
`define EBT_CFG_RATIO_HI 2
`define EBT_CFG_RATIO_LO 0

// interrupt control register fields
`define EBT_INT_FLAG 2
`define EBT_INT_EN 5

// reset values and the count value that wraps to zero
`define EBT_CFG_RESET 6'h3F
`define EBT_COUNT_RESET 8'h00
`define EBT_COUNT_MAX 8'hFF
`define EBT_PRESC_RESET 8'h00

// timing: clock is the oscillator, instruction cycle is four phases
`define EBT_TOSC_NS 25
`define EBT_INHIBIT_CYCLES 2'h2

`endif

//--- hdl/ebt_pkg.sv
// types shared by the 8-bit timer and its prescaler
// assumes the oscillator clock drives all logic
package ebt_pkg;

   // one-hot instruction cycle phases, one per oscillator period
   typedef enum logic [3:0] {
      PH_Q1 = 4'h1,
      PH_Q2 = 4'h2,
      PH_Q3 = 4'h4,
      PH_Q4 = 4'h8
   } ebt_phase_t;

endpackage

//--- hdl/ebt_prescaler.sv
// shared 8-bit prescaler: counts step pulses, taps one bit as its output
// assumes step and clear come from logic on the same clock
`timescale 1ns/10ps
`include "ebt_params.svh"

module ebt_prescaler
   import ebt_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic clear,
   input wire logic step,
   input wire logic [2:0] ratio,
   output logic tap,
   output logic [7:0] count
);

   logic [7:0] next_count;

   always_comb begin
      next_count = count;
      if (clear) begin
         next_count = `EBT_PRESC_RESET;
      end else if (step) begin
         next_count = count + 8'h01;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         count <= `EBT_PRESC_RESET;
      end else begin
         count <= next_count;
      end
   end

   // bit n completes one period every 2^(n+1) steps
   assign tap = count[ratio]; // see RULE17

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   a_presc_clear_wins: assert property (clear |=> count == 8'h00) // see RULE14
      else $error("prescaler not cleared");
   a_presc_step_one: assert property (!clear && step |=> count == $past(count) + 8'h01) // see RULE6
      else $error("prescaler did not step by one");

endmodule

//--- hdl/ebt_timer.sv
// 8-bit timer/counter with a prescaler shared with the watchdog
// assumes sleepMode, wdtTick and wdtClear come from core logic on clk;
// countInputPin is asynchronous and is synchronised here
//
// Summary of operation
// RULE1: source is instruction clock or count pin
// RULE2: source bit clear counts each instruction cycle
// RULE3: count write blocks increments two instruction cycles
// RULE4: source set counts pin edges, edge bit selects
// RULE5: prescaler serves counter or watchdog, never both
// RULE6: ratio field sets 1:2..1:256, watchdog gives 1:1
// RULE7: prescaler count never visible to software
// RULE8: wrap from FF to 00 sets overflow flag
// RULE9: enable bit gates the overflow interrupt
// RULE10: software clears flag, hardware never does
// RULE11: sleep halts counter, no overflow occurs
// RULE12: pin edges feed prescaler before sampling
// RULE13: source sampled on second and fourth phases
// RULE14: count write clears prescaler if counter owns it
// RULE15: watchdog clear clears prescaler if watchdog owns it
// RULE16: pin edge reaches count within 3..7 oscillator periods
// RULE17: ratio n selects divide by 2^(n+1)
// RULE18: watchdog ticks pass prescaler as postscaled timeout
//
// Implementation choices: register access over Avalon-MM and the register offsets.
`timescale 1ns/10ps
`include "ebt_params.svh"

module ebt_timer
   import ebt_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [3:0] address,
   input wire logic read,
   input wire logic write,
   input wire logic [31:0] writedata,
   output logic [31:0] readdata,
   output logic waitrequest,
   input wire logic countInputPin,
   input wire logic sleepMode,
   input wire logic wdtTick,
   input wire logic wdtClear,
   output logic wdtTimeout,
   output logic irq
);

   // instruction cycle phase and pin synchroniser
   ebt_phase_t phase;
   ebt_phase_t next_phase;
   logic pinMeta;
   logic pinSync;
   logic pinPrev;

   always_comb begin
      case (phase)
         PH_Q1: next_phase = PH_Q2;
         PH_Q2: next_phase = PH_Q3;
         PH_Q3: next_phase = PH_Q4;
         PH_Q4: next_phase = PH_Q1;
         default: next_phase = PH_Q1;
      endcase
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         phase <= PH_Q1;
         pinMeta <= 1'b0;
         pinSync <= 1'b0;
         pinPrev <= 1'b0;
      end else begin
         phase <= next_phase;
         pinMeta <= countInputPin;
         pinSync <= pinMeta; // see RULE16
         pinPrev <= pinSync;
      end
   end

   // register state
   logic [7:0] count;
   logic [5:0] cfg;
   logic ovfFlag;
   logic ovfEn;
   logic [1:0] inhCnt;
   logic sampLvl;
   logic wdtTapPrev;
   logic [7:0] next_count;
   logic [5:0] next_cfg;
   logic next_ovfFlag;
   logic next_ovfEn;
   logic [1:0] next_inhCnt;
   logic next_sampLvl;
   logic next_wdtTimeout;
   logic next_irq;

   // bus decode
   logic wrAcc;
   logic wrCount;
   logic wrCfg;
   logic wrIntctl;
   logic [31:0] next_readdata;
   logic next_waitrequest;

   assign wrAcc = write && !waitrequest;
   assign wrCount = wrAcc && (address == `EBT_ADDR_COUNT);
   assign wrCfg = wrAcc && (address == `EBT_ADDR_CFG);
   assign wrIntctl = wrAcc && (address == `EBT_ADDR_INTCTL);

   // configuration decode
   logic srcCounter;
   logic edgeFall;
   logic psaWdt;
   logic [2:0] ratio;

   assign srcCounter = cfg[`EBT_CFG_SRC];
   assign edgeFall = cfg[`EBT_CFG_EDGE];
   assign psaWdt = cfg[`EBT_CFG_PSA];
   assign ratio = cfg[`EBT_CFG_RATIO_HI:`EBT_CFG_RATIO_LO];

   // event path
   logic run;
   logic pinLvl;
   logic pinEdge;
   logic baseEvent;
   logic prescStep;
   logic prescClear;
   logic prescTap;
   logic [7:0] prescCount;
   logic srcLvl;
   logic sampleNow;
   logic srcRise;
   logic incTick;
   logic doInc;

   assign run = !sleepMode; // see RULE11
   // falling-edge mode inverts the pin so both modes look for a rise
   assign pinLvl = pinSync ^ edgeFall; // see RULE4
   assign pinEdge = pinLvl && !(pinPrev ^ edgeFall);
   assign baseEvent = srcCounter ? pinEdge : (phase == PH_Q4); // see RULE1

   // the watchdog owns the prescaler input whenever assigned to it
   assign prescStep = psaWdt ? wdtTick : (baseEvent && run); // see RULE5 RULE12 RULE18
   assign prescClear = (wrCount && !psaWdt) || (wdtClear && psaWdt); // see RULE14 RULE15

   ebt_prescaler u_prescaler (
      .clk(clk),
      .rst_n(rst_n),
      .clear(prescClear),
      .step(prescStep),
      .ratio(ratio),
      .tap(prescTap),
      .count(prescCount)
   );

   // without the prescaler the pin itself is what gets sampled
   assign srcLvl = (srcCounter && psaWdt) ? pinLvl : prescTap; // see RULE6 RULE13
   // pin-derived sources are only looked at on the second and fourth phase
   assign sampleNow = srcCounter ? (phase == PH_Q2 || phase == PH_Q4) : 1'b1; // see RULE13
   assign srcRise = sampleNow && srcLvl && !sampLvl;
   // timer mode with no prescaler steps once per instruction cycle
   assign incTick = (!srcCounter && psaWdt) ? (phase == PH_Q4) : srcRise; // see RULE2
   assign doInc = incTick && run && (inhCnt == 2'h0) && !wrCount; // see RULE3 RULE11

   always_comb begin
      next_count = count;
      if (wrCount) begin
         next_count = writedata[7:0];
      end else if (doInc) begin
         next_count = count + 8'h01;
      end
   end

   always_comb begin
      next_inhCnt = inhCnt;
      if (wrCount) begin
         next_inhCnt = `EBT_INHIBIT_CYCLES; // see RULE3
      end else if (inhCnt != 2'h0 && phase == PH_Q4) begin
         next_inhCnt = inhCnt - 2'h1;
      end
   end

   always_comb begin
      next_sampLvl = sampLvl;
      if (sampleNow) begin
         next_sampLvl = srcLvl;
      end
   end

   always_comb begin
      next_cfg = cfg;
      if (wrCfg) begin
         next_cfg = writedata[5:0];
      end
   end

   // a wrap in the same cycle as a write-one clear keeps the flag set
   always_comb begin
      next_ovfFlag = ovfFlag;
      if (wrIntctl && writedata[`EBT_INT_FLAG]) begin
         next_ovfFlag = 1'b0; // see RULE10
      end
      if (doInc && count == `EBT_COUNT_MAX) begin
         next_ovfFlag = 1'b1; // see RULE8
      end
   end

   always_comb begin
      next_ovfEn = ovfEn;
      if (wrIntctl) begin
         next_ovfEn = writedata[`EBT_INT_EN];
      end
   end

   assign next_irq = next_ovfFlag && next_ovfEn; // see RULE9

   // watchdog timeout: raw tick at 1:1, else each rise of the tap
   assign next_wdtTimeout = psaWdt ? (prescTap && !wdtTapPrev) : wdtTick; // see RULE18

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         count <= `EBT_COUNT_RESET;
         cfg <= `EBT_CFG_RESET;
         ovfFlag <= 1'b0;
         ovfEn <= 1'b0;
         inhCnt <= 2'h0;
         // reset config counts falling edges of an idle-low pin, so the level seen is high
         sampLvl <= 1'b1;
         wdtTapPrev <= 1'b0;
         wdtTimeout <= 1'b0;
         irq <= 1'b0;
      end else begin
         count <= next_count;
         cfg <= next_cfg;
         ovfFlag <= next_ovfFlag;
         ovfEn <= next_ovfEn;
         inhCnt <= next_inhCnt;
         sampLvl <= next_sampLvl;
         wdtTapPrev <= prescTap;
         wdtTimeout <= next_wdtTimeout;
         irq <= next_irq;
      end
   end

   // bus answer: one wait cycle, then waitrequest low for one cycle
   always_comb begin
      next_waitrequest = !((read || write) && waitrequest);
      next_readdata = readdata;
      if (read && waitrequest) begin
         case (address)
            `EBT_ADDR_COUNT: next_readdata = {24'h000000, count};
            `EBT_ADDR_CFG: next_readdata = {26'h0000000, cfg};
            `EBT_ADDR_INTCTL: next_readdata = {26'h0000000, ovfEn, 2'h0, ovfFlag, 2'h0};
            // the prescaler count has no address of its own
            default: next_readdata = 32'h00000000; // see RULE7
         endcase
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         waitrequest <= 1'b1;
         readdata <= 32'h00000000;
      end else begin
         waitrequest <= next_waitrequest;
         readdata <= next_readdata;
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   a_ovf_sets_flag: assert property (doInc && count == 8'hFF |=> ovfFlag && count == 8'h00) // see RULE8
      else $error("wrap did not set the overflow flag");
   a_irq_needs_enable: assert property (irq |-> ovfEn && ovfFlag) // see RULE9
      else $error("interrupt raised while masked or without flag");
   a_flag_sticks: assert property (ovfFlag && !wrIntctl |=> ovfFlag) // see RULE10
      else $error("overflow flag cleared without software");
   a_write_inhibit: assert property (wrCount |=> count == $past(writedata[7:0]) ##1 ($past(wrCount) || $stable(count)) [*4]) // see RULE3
      else $error("count moved inside the inhibit window");
   a_sleep_halts: assert property (sleepMode && !wrCount |=> count == $past(count)) // see RULE11
      else $error("count moved during sleep");
   a_timer_rate: assert property (!srcCounter && psaWdt && !sleepMode && inhCnt == 2'h0
      && !wrCount && phase == PH_Q4 |=> count == $past(count) + 8'h01) // see RULE2
      else $error("timer mode missed an instruction cycle");
   a_timer_idle: assert property (!srcCounter && psaWdt && phase != PH_Q4 && !wrCount
      |=> count == $past(count)) // see RULE2
      else $error("timer moved off the fourth phase");
   a_ext_sample_phase: assert property (srcCounter && !$past(wrCount) && count != $past(count)
      && $past(rst_n) |-> $past(phase == PH_Q2 || phase == PH_Q4)) // see RULE13
      else $error("counter mode increment off a sampling phase");
   a_pin_latency: assert property (srcCounter && psaWdt && !sleepMode && pinEdge // see RULE16
      && inhCnt == 2'h0 && !wrCount |-> ##[1:2] $changed(count))
      else $error("pin edge not counted in time");
   a_presc_wr_clear: assert property (wrCount && !psaWdt |=> prescCount == 8'h00) // see RULE14
      else $error("count write left the prescaler running");
   a_presc_wdt_clear: assert property (wdtClear && psaWdt |=> prescCount == 8'h00) // see RULE15
      else $error("watchdog clear left the prescaler running");
   a_wdt_passthru: assert property (!psaWdt && wdtTick |=> wdtTimeout) // see RULE5
      else $error("unassigned watchdog tick lost");
   a_bus_answer: assert property ((read || write) && waitrequest |=> !waitrequest) // see RULE7
      else $error("bus request not answered in one cycle");
   a_edge_latency: assert property (srcCounter && psaWdt && !sleepMode && pinEdge
      && inhCnt == 2'h0 && !wrCount |-> ##[0:1] srcRise) // see RULE13
      else $error("pin edge not sampled in time");

endmodule

//--- dv/ebt_pulse_source.sv
// count pin source: bursts of whole pulses, low at rest
// assumes clk is the timer clock; the pin moves just after rising edges
`timescale 1ns/10ps

module ebt_pulse_source (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic go,
   input wire logic [8:0] pulses,
   input wire logic [3:0] half,
   output logic pin,
   output logic busy
);
   logic [8:0] left;
   logic [3:0] ph;

   assign busy = left != 9'h000;

   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pin <= 1'b0;
         left <= 9'h000;
         ph <= 4'h0;
      end else if (busy) begin
         // each level stands half clocks, two at least so raw sampling sees it
         if (ph == half - 4'h1) begin
            ph <= 4'h0;
            pin <= ~pin;
            if (pin) begin
               left <= left - 9'h001;
            end
         end else begin
            ph <= ph + 4'h1;
         end
      end else if (go) begin
         left <= pulses;
         ph <= 4'h0;
      end
   end
endmodule

//--- dv/test_eight_bit_timer_with_shared_prescaler.sv
// self-checking bench for the 8-bit timer: bus tasks, pin bursts, watchdog ticks
// assumes one wait cycle per bus access and a 40 MHz oscillator clock
`timescale 1ns/10ps
`include "ebt_params.svh"

module test_eight_bit_timer_with_shared_prescaler;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic [3:0] address = 4'h0;
   logic read = 1'b0;
   logic write = 1'b0;
   logic [31:0] writedata = 32'h0;
   logic [31:0] readdata;
   logic waitrequest;
   logic countInputPin;
   logic sleepMode = 1'b0;
   logic wdtTick = 1'b0;
   logic wdtClear = 1'b0;
   logic wdtTimeout;
   logic irq;
   logic go = 1'b0;
   logic [8:0] pulses = 9'h000;
   logic [3:0] half = 4'h3;
   logic busy;
   logic [15:0] lfsr = 16'h68D8;
   logic [31:0] q;
   logic [31:0] v;
   int mismatches = 0;
   int check_count = 0;
   int timeouts = 0;

   always #12.5 clk = ~clk;

   ebt_timer u_dut (.clk(clk), .rst_n(rst_n), .address(address), .read(read), .write(write),
      .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
      .countInputPin(countInputPin), .sleepMode(sleepMode), .wdtTick(wdtTick),
      .wdtClear(wdtClear), .wdtTimeout(wdtTimeout), .irq(irq));

   ebt_pulse_source u_src (.clk(clk), .rst_n(rst_n), .go(go), .pulses(pulses), .half(half),
      .pin(countInputPin), .busy(busy));

   always @(posedge clk) begin
      if (wdtTimeout === 1'b1) begin
         timeouts <= timeouts + 1;
      end
   end

   function automatic logic [15:0] nextRand(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction

   function automatic logic [8:0] pulsesFor(input int r);
      return 9'(1 << (r + 1));
   endfunction

   task automatic final_report;
      if (mismatches == 0 && check_count > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   task automatic check(input logic [31:0] got, input logic [31:0] lo, input logic [31:0] hi);
      check_count++;
      if (((got >= lo) && (got <= hi)) !== 1'b1) begin
         $display("CHECK FAILED at %0t: got %h expected %h to %h", $time, got, lo, hi);
         mismatches++;
      end
   endtask

   task automatic bus(input logic wr, input logic [3:0] adr, input logic [31:0] d);
      int n;
      n = 0;
      address <= adr;
      writedata <= d;
      write <= wr;
      read <= ~wr;
      @(posedge clk);
      while (waitrequest !== 1'b0 && n < 20) begin
         @(posedge clk);
         n++;
      end
      if (n == 20) begin
         mismatches++;
         final_report();
      end
      q = readdata;
      write <= 1'b0;
      read <= 1'b0;
      @(posedge clk);
   endtask

   task automatic burst(input logic [8:0] n);
      int w;
      w = 0;
      pulses <= n;
      half <= 4'h2 + {2'b00, lfsr[1:0]};
      lfsr = nextRand(lfsr);
      go <= 1'b1;
      @(posedge clk);
      go <= 1'b0;
      @(posedge clk);
      while (busy && w < 9000) begin
         @(posedge clk);
         w++;
      end
      // room for synchroniser and phase sampling before the count is read
      repeat (12) @(posedge clk);
   endtask

   initial begin
      repeat (40000) @(posedge clk);
      mismatches++;
      final_report();
   end

   initial begin
      repeat (10) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      bus(1'b0, `EBT_ADDR_CFG, 32'h0);
      check(q, 32'h3F, 32'h3F);
      bus(1'b1, 4'hC, 32'hFFFFFFFF);
      bus(1'b0, 4'hC, 32'h0);
      check(q, 32'h0, 32'h0);
      // timer mode, prescaler on the watchdog: one step per four clocks
      bus(1'b1, `EBT_ADDR_CFG, 32'h08);
      v = {25'h0, lfsr[6:0]};
      lfsr = nextRand(lfsr);
      bus(1'b1, `EBT_ADDR_COUNT, v);
      repeat (39) @(posedge clk);
      bus(1'b0, `EBT_ADDR_COUNT, 32'h0);
      check(q, v + 32'h7, v + 32'h8);
      v = q;
      repeat (37) @(posedge clk);
      bus(1'b0, `EBT_ADDR_COUNT, 32'h0);
      check(q, v + 32'hA, v + 32'hA);
      // overflow with the interrupt masked, then unmasked, then cleared
      bus(1'b1, `EBT_ADDR_COUNT, 32'hFE);
      repeat (40) @(posedge clk);
      bus(1'b0, `EBT_ADDR_INTCTL, 32'h0);
      check(q, 32'h04, 32'h04);
      check({31'h0, irq}, 32'h0, 32'h0);
      bus(1'b1, `EBT_ADDR_INTCTL, 32'h20);
      repeat (2) @(posedge clk);
      check({31'h0, irq}, 32'h1, 32'h1);
      bus(1'b1, `EBT_ADDR_INTCTL, 32'h24);
      repeat (2) @(posedge clk);
      check({31'h0, irq}, 32'h0, 32'h0);
      bus(1'b0, `EBT_ADDR_INTCTL, 32'h0);
      check(q, 32'h20, 32'h20);
      // sleep freezes the count
      sleepMode <= 1'b1;
      bus(1'b0, `EBT_ADDR_COUNT, 32'h0);
      v = q;
      repeat (37) @(posedge clk);
      bus(1'b0, `EBT_ADDR_COUNT, 32'h0);
      check(q, v, v);
      sleepMode <= 1'b0;
      // pin edges counted one for one, both edge choices
      for (int e = 0; e < 2; e++) begin
         bus(1'b1, `EBT_ADDR_CFG, 32'h28 | (e << 4));
         bus(1'b1, `EBT_ADDR_COUNT, 32'h0);
         v = {27'h0, lfsr[4:0]} + 32'h1;
         lfsr = nextRand(lfsr);
         burst(v[8:0]);
         bus(1'b0, `EBT_ADDR_COUNT, 32'h0);
         check(q, v, v);
      end
      // every ratio: 2^(r+1) pin pulses give one step
      for (int r = 0; r < 8; r++) begin
         bus(1'b1, `EBT_ADDR_CFG, 32'h20 | r);
         bus(1'b1, `EBT_ADDR_COUNT, 32'h0);
         repeat (12) @(posedge clk);
         burst(pulsesFor(r));
         bus(1'b0, `EBT_ADDR_COUNT, 32'h0);
         check(q, 32'h1, 32'h1);
      end
      // a count write empties a divide-by-four prescaler holding one step
      bus(1'b1, `EBT_ADDR_CFG, 32'h21);
      bus(1'b1, `EBT_ADDR_COUNT, 32'h0);
      burst(9'h001);
      bus(1'b1, `EBT_ADDR_COUNT, 32'h10);
      repeat (12) @(posedge clk);
      burst(9'h001);
      bus(1'b0, `EBT_ADDR_COUNT, 32'h0);
      check(q, 32'h10, 32'h10);
      // watchdog owns a divide-by-two prescaler, cleared before each tick
      bus(1'b1, `EBT_ADDR_CFG, 32'h08);
      // handing over a part-filled prescaler can pulse the timeout once; let it pass
      repeat (4) @(posedge clk);
      v = timeouts;
      for (int t = 0; t < 6; t++) begin
         wdtClear <= t[0] == 1'b0;
         wdtTick <= t[0] == 1'b1;
         @(posedge clk);
         wdtClear <= 1'b0;
         wdtTick <= 1'b0;
         repeat (6) @(posedge clk);
      end
      check(timeouts, v + 32'h3, v + 32'h3);
      // prescaler on the counter: ticks pass straight through
      bus(1'b1, `EBT_ADDR_CFG, 32'h00);
      v = timeouts;
      for (int t = 0; t < 3; t++) begin
         wdtTick <= 1'b1;
         @(posedge clk);
         wdtTick <= 1'b0;
         repeat (6) @(posedge clk);
      end
      check(timeouts, v + 32'h3, v + 32'h3);
      final_report();
   end
endmodule
